// ### psc_conv_ctrl.v
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "psc_regs.vh"

module psc_conv_ctrl #(
	parameter CONV_HALF_EDGES = `PSC_CONV_HALF_EDGES,
	parameter INT_CLK_DIV     = `PSC_INT_CLK_DIV
) (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire [2:0]  pair_sample_start_i,
	input  wire        external_conversion_clock_i,
	input  wire        range_pin_i,
	output wire        busy_o,
	output reg  [2:0]  pair_hold_o,
	output reg  [2:0]  pair_precharge_o,
	output reg  [2:0]  pair_power_down_o,
	output reg  [2:0]  pair_range_o,
	output reg         reference_level_o,
	output reg         conv_clock_tick_o,
	output reg         results_load_o,
	output wire        irq_o
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Only the second stage of each synchroniser feeds logic; the first may be metastable.
	reg [2:0] start_meta;
	reg [2:0] start_sync;
	reg [2:0] start_prev;
	reg       external_conversion_clock_meta;
	reg       external_conversion_clock_sync;
	reg       external_conversion_clock_prev;
	reg       range_meta;
	reg       range_sync;

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			start_meta <= 3'h0;
			start_sync <= 3'h0;
			start_prev <= 3'h0;
			external_conversion_clock_meta  <= 1'h0;
			external_conversion_clock_sync  <= 1'h0;
			external_conversion_clock_prev  <= 1'h0;
			range_meta <= 1'h0;
			range_sync <= 1'h0;
		end else begin
			start_meta <= pair_sample_start_i;
			start_sync <= start_meta;
			start_prev <= start_sync;
			external_conversion_clock_meta  <= external_conversion_clock_i;
			external_conversion_clock_sync  <= external_conversion_clock_meta;
			external_conversion_clock_prev  <= external_conversion_clock_sync;
			range_meta <= range_pin_i;
			range_sync <= range_meta;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [31:0]             control_word;
	reg  [`PSC_IRQ_W-1:0]   irq_stat;
	reg  [`PSC_IRQ_W-1:0]   irq_mask;
	wire                    sw_mode  = control_word[`PSC_CTRL_SW_MODE];
	wire                    seq_mode = control_word[`PSC_CTRL_SEQ_MODE];
	wire                    busy_pol = control_word[`PSC_CTRL_BUSY_POL];
	wire                    use_external_conversion_clock = sw_mode & control_word[`PSC_CTRL_CLK_SOURCE];
	// A request is taken once; the registered ack masks it in the following cycle.
	wire                    wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	function [31:0] psc_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  sel;
		integer      k;
		begin
			psc_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					psc_merge[k*8 +: 8] = new_v[k*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Conversion clock selection
	// ----------------------------------------------------------------
	reg  [3:0] int_div;
	reg        int_tick;
	// Both edges of the external clock count, so each stands for one half cycle.
	// The internal divider gives one edge every INT_CLK_DIV system clocks.
	wire       external_conversion_clock_edge = external_conversion_clock_sync ^ external_conversion_clock_prev;

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			int_div  <= 4'h0;
			int_tick <= 1'b0;
		end else if (int_div == INT_CLK_DIV - 4'd1) begin
			int_div  <= 4'h0;
			int_tick <= 1'b1;
		end else begin
			int_div  <= int_div + 4'd1;
			int_tick <= 1'b0;
		end
	end

	// Each tick is one conversion clock edge (half cycle); a stopped external clock gives none.
	wire conv_edge = use_external_conversion_clock ? external_conversion_clock_edge : int_tick;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	localparam ST_IDLE  = 2'b00;
	localparam ST_ARMED = 2'b01;
	localparam ST_CONV  = 2'b10;
	localparam ST_GAP   = 2'b11;
	localparam [2:0] ALL_PAIRS = 3'h7;

	reg  [1:0] state;
	reg  [5:0] edge_cnt;
	reg  [2:0] active;
	reg        busy;
	reg        busy_prev;
	wire [2:0] rise = start_sync & ~start_prev;
	wire [2:0] fall = ~start_sync & start_prev;
	wire       any_rise = |rise;
	wire [2:0] trig = (sw_mode & ~seq_mode) ? {3{rise[0]}} : rise;
	wire       start_ok = (state == ST_IDLE) | (state == ST_GAP) | seq_mode;
	wire       launch = (|trig) & start_ok & ~(busy & ~seq_mode);
	// A refused start is reported so that software can see a lost trigger.
	wire       blocked = any_rise & ~launch;
	wire [2:0] dropped = fall & active & {3{busy}};

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			state             <= ST_IDLE;
			edge_cnt          <= 6'h0;
			active            <= 3'h0;
			busy              <= 1'b0;
			pair_hold_o       <= 3'h0;
			pair_precharge_o  <= 3'h0;
			conv_clock_tick_o <= 1'b0;
			results_load_o    <= 1'b0;
		end else begin
			conv_clock_tick_o <= conv_edge & busy;
			results_load_o    <= 1'b0;
			active            <= active & ~dropped;
			// A launch restarts the count; in sequential mode it may cut a running conversion short.
			if (launch) begin
				busy              <= 1'b1;
				active            <= trig;
				pair_hold_o       <= trig;
				pair_precharge_o  <= 3'h0;
				edge_cnt          <= 6'h0;
				state             <= ST_ARMED;
			end else begin
				case (state)
					ST_IDLE: begin
						pair_precharge_o <= ALL_PAIRS;
						pair_hold_o      <= 3'h0;
					end
					ST_ARMED: begin
						if (conv_edge) begin
							state <= ST_CONV;
						end
					end
					ST_CONV: begin
						if (conv_edge) begin
							edge_cnt <= edge_cnt + 6'd1;
							// The arm edge plus CONV_HALF_EDGES - 1 counted edges make up the conversion.
							if (edge_cnt == CONV_HALF_EDGES - 6'd2) begin
								results_load_o <= 1'b1;
								busy           <= 1'b0;
								pair_hold_o    <= 3'h0;
								pair_precharge_o <= active;
								state          <= seq_mode ? ST_GAP : ST_IDLE;
							end
						end
					end
					ST_GAP: begin
						state <= ST_IDLE;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Partial power-down
	// ----------------------------------------------------------------
	// A pair that loses its start mid-conversion stays powered down until it is launched again.
	// A refused start leaves the flag alone, so a blocked edge cannot wake the pair.
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			pair_power_down_o <= 3'h0;
		end else begin
			pair_power_down_o <= (pair_power_down_o | dropped) & ~(trig & {3{launch}});
		end
	end

	// ----------------------------------------------------------------
	// Range and reference outputs
	// ----------------------------------------------------------------
	wire busy_fell = busy_prev & ~busy;

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			busy_prev         <= 1'b0;
			pair_range_o      <= 3'h0;
			reference_level_o <= 1'b0;
		end else begin
			busy_prev         <= busy;
			reference_level_o <= control_word[`PSC_CTRL_REF_LEVEL];
			// Software mode applies the range bits at once; hardware mode latches the pin at busy fall only while the polarity bit is clear.
			if (sw_mode) begin
				pair_range_o <= control_word[`PSC_CTRL_RANGE_C:`PSC_CTRL_RANGE_A];
			end else if (busy_fell & ~busy_pol) begin
				pair_range_o <= {3{range_sync}};
			end
		end
	end

	// The polarity bit flips the pin sense and, when set, stops the hardware-mode range latch; internal logic always uses the true busy.
	assign busy_o = busy ^ busy_pol;

	// ----------------------------------------------------------------
	// Wishbone slave and interrupts
	// ----------------------------------------------------------------
	wire [`PSC_IRQ_W-1:0] irq_set = {blocked, |dropped, busy_fell};
	wire                  rd_stat = wb_req & ~wb_we_i & (wb_adr_i == `PSC_OFS_IRQ_STAT);

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			control_word <= `PSC_CTRL_RESET;
			irq_stat     <= {`PSC_IRQ_W{1'b0}};
			irq_mask     <= {`PSC_IRQ_W{1'b0}};
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			// A read clears the status, but an event in the same cycle still sets its bit.
			irq_stat <= (rd_stat ? {`PSC_IRQ_W{1'b0}} : irq_stat) | irq_set;
			if (wb_req & wb_we_i) begin
				case (wb_adr_i)
					`PSC_OFS_CTRL: begin
						control_word <= psc_merge(control_word, wb_dat_i, wb_sel_i);
					end
					`PSC_OFS_IRQ_MASK: begin
						irq_mask <= wb_sel_i[0] ? wb_dat_i[`PSC_IRQ_W-1:0] : irq_mask;
					end
					default: begin
					end
				endcase
			end
			// Status word: power-down flags, active pairs, sequencer state and busy.
			if (wb_req & ~wb_we_i) begin
				case (wb_adr_i)
					`PSC_OFS_CTRL:     wb_dat_o <= control_word;
					`PSC_OFS_STATUS:   wb_dat_o <= {19'h0, pair_power_down_o, 3'h0, active, 1'b0, state, busy};
					`PSC_OFS_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
					`PSC_OFS_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
					default:           wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

endmodule

// ### psc_conv_ctrl_props.sv
`timescale 1ns/1ps
module psc_conv_ctrl_props (
	input logic       clk_sys_i,
	input logic       rst_i,
	input logic       wb_cyc_i,
	input logic       wb_stb_i,
	input logic       wb_ack_o,
	input logic [2:0] pair_sample_start_i,
	input logic       busy_o,
	input logic [2:0] pair_hold_o,
	input logic [2:0] pair_precharge_o,
	input logic [2:0] pair_power_down_o,
	input logic       conv_clock_tick_o,
	input logic       results_load_o
);
	logic       conv;
	logic       held;
	logic       held_d;
	logic [7:0] ticks;
	assign held = pair_hold_o != 3'h0;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Tracks one conversion from the first held pair to the result load.
	always @(posedge clk_sys_i) begin
		held_d <= held;
		conv <= !rst_i && (conv ? !results_load_o : held && !held_d);
		ticks <= conv ? ticks + {7'h00, conv_clock_tick_o} : 8'h00;
	end
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_hold_cause: assert property ($rose(pair_hold_o[1]) |-> pair_sample_start_i[1] || pair_sample_start_i[0])
		else $error("hold without start");
	a_no_join: assert property (conv && !results_load_o |=> (pair_hold_o & ~$past(pair_hold_o)) == 3'h0)
		else $error("start not blocked");
	a_pdown_drop: assert property (conv && pair_hold_o[2] && $fell(pair_sample_start_i[2]) |-> ##[1:5] pair_power_down_o[2])
		else $error("no power down");
	a_conv_length: assert property (results_load_o && conv |-> ticks >= 8'd34 && ticks <= 8'd38)
		else $error("bad conversion length");
	a_busy_rise: assert property ($rose(held) |-> ##[0:1] $changed(busy_o))
		else $error("busy did not rise");
	a_busy_fall: assert property ($rose(results_load_o) |-> ##[0:1] $changed(busy_o))
		else $error("busy did not fall");
	a_precharge_end: assert property ($rose(results_load_o) |-> ##[0:1] pair_precharge_o != 3'h0)
		else $error("no precharge");
	cover property ($rose(results_load_o));
	cover property ($rose(pair_power_down_o[2]));
	cover property (pair_hold_o == 3'h7);
endmodule

bind psc_conv_ctrl psc_conv_ctrl_props props_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pair_sample_start_i(pair_sample_start_i), .busy_o(busy_o),
	.pair_hold_o(pair_hold_o), .pair_precharge_o(pair_precharge_o), .pair_power_down_o(pair_power_down_o),
	.conv_clock_tick_o(conv_clock_tick_o), .results_load_o(results_load_o));

// ### psc_host_model.sv
`timescale 1ns/1ps
module psc_host_model (
	input  logic       clk_sys_i,
	input  logic [2:0] start_req_i,
	input  logic       clock_run_i,
	output logic [2:0] pair_sample_start_o,
	output logic       external_conversion_clock_o
);
	logic [1:0] div = 2'h0;
	// Starts move together, so the pairs see no skew.
	assign pair_sample_start_o = start_req_i;
	// Even division keeps the duty cycle at one half; the clock parks low when stopped.
	always @(posedge clk_sys_i) begin
		div <= clock_run_i ? div + 2'h1 : 2'h0;
	end
	assign external_conversion_clock_o = clock_run_i & div[1];
endmodule

// ### psc_regs.vh
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PSC_OFS_CTRL        4'h0
`define PSC_OFS_STATUS      4'h4
`define PSC_OFS_IRQ_STAT    4'h8
`define PSC_OFS_IRQ_MASK    4'hc

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define PSC_CTRL_SW_MODE     0
`define PSC_CTRL_SEQ_MODE    1
`define PSC_CTRL_RANGE_A     2
`define PSC_CTRL_RANGE_B     3
`define PSC_CTRL_RANGE_C     4
`define PSC_CTRL_REF_LEVEL   18
`define PSC_CTRL_CLK_SOURCE  11
`define PSC_CTRL_BUSY_POL    20
`define PSC_CTRL_RESET       32'h0000_0000

// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define PSC_IRQ_DONE         0
`define PSC_IRQ_PDOWN        1
`define PSC_IRQ_BLOCKED      2
`define PSC_IRQ_W            3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSC_CONV_HALF_EDGES  6'd37
`define PSC_INT_CLK_DIV      4'd2

`endif

// ### psc_tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, rng_pin = 1'b0;
	logic [3:0]  adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic [2:0]  req = 3'h0, start, hold, pre, pdn, rng;
	logic        ext_clk, ack, busy, irq, tick, load, refl;
	int          bad_count = 0;
	int          compares = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	psc_host_model host_u (.clk_sys_i(clk_sys_i), .start_req_i(req), .clock_run_i(run),
		.pair_sample_start_o(start), .external_conversion_clock_o(ext_clk));
	psc_conv_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.pair_sample_start_i(start), .external_conversion_clock_i(ext_clk), .range_pin_i(rng_pin),
		.busy_o(busy), .pair_hold_o(hold), .pair_precharge_o(pre), .pair_power_down_o(pdn),
		.pair_range_o(rng), .reference_level_o(refl), .conv_clock_tick_o(tick),
		.results_load_o(load), .irq_o(irq));
	task test_done;
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task give_up;
		bad_count++;
		$display("[FAIL] wait expected answer seen none");
		test_done;
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) give_up;
		rdat = dat_o;
		{cyc, stb, we} <= 3'h0;
	endtask
	task go(input logic [2:0] r, input logic x, input int c);
		@(posedge clk_sys_i);
		{req, run} <= {r, x};
		repeat (c) @(posedge clk_sys_i);
	endtask
	task wait_load;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (load !== 1'b1 && n < 400);
		if (load !== 1'b1) give_up;
	endtask
	task s_reset;
		chk("busy", 32'h0, 32'(busy));
		chk("range", 32'h0, 32'(rng));
		bus(1'b0, 4'h0, 32'h0);
		chk("control", 32'h0, rdat);
		bus(1'b0, 4'hc, 32'h0);
		chk("mask", 32'h0, rdat);
	endtask
	task s_hw;
		bus(1'b1, 4'hc, 32'h7);
		rng_pin <= 1'b1;
		go(3'h5, 1'b0, 4);
		chk("busy", 32'h1, 32'(busy));
		chk("hold", 32'h5, 32'(hold));
		chk("precharge", 32'h0, 32'(pre));
		go(3'h7, 1'b0, 5);
		chk("hold", 32'h5, 32'(hold));
		wait_load;
		repeat (2) @(posedge clk_sys_i);
		chk("busy", 32'h0, 32'(busy));
		chk("range", 32'h7, 32'(rng));
		chk("precharge", 32'h7, 32'(pre));
		chk("irq", 32'h1, 32'(irq));
		bus(1'b0, 4'h8, 32'h0);
		chk("status", 32'h5, rdat);
		go(3'h0, 1'b0, 4);
		chk("irq", 32'h0, 32'(irq));
	endtask
	task s_abort;
		go(3'h7, 1'b0, 14);
		go(3'h0, 1'b0, 6);
		chk("power down", 32'h7, 32'(pdn));
		bus(1'b0, 4'h4, 32'h0);
		chk("status", 32'h0000_1c01, rdat & 32'h0000_1c71);
		bus(1'b0, 4'h8, 32'h0);
		chk("status", 32'h2, rdat & 32'h2);
		repeat (100) @(posedge clk_sys_i);
	endtask
	task s_sw;
		bus(1'b1, 4'h0, 32'h0014_0815);
		bus(1'b0, 4'h0, 32'h0);
		chk("control", 32'h0014_0815, rdat);
		chk("reference", 32'h1, 32'(refl));
		chk("range", 32'h5, 32'(rng));
		chk("busy", 32'h1, 32'(busy));
		go(3'h1, 1'b0, 100);
		chk("hold", 32'h7, 32'(hold));
		chk("busy", 32'h0, 32'(busy));
		go(3'h1, 1'b1, 0);
		wait_load;
		chk("busy", 32'h1, 32'(busy));
		go(3'h0, 1'b0, 2);
		chk("power down", 32'h0, 32'(pdn));
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rdat);
	endtask
	task s_seq;
		bus(1'b1, 4'h0, 32'h0000_0003);
		go(3'h2, 1'b0, 4);
		chk("hold", 32'h2, 32'(hold));
		chk("busy", 32'h1, 32'(busy));
		wait_load;
		go(3'h6, 1'b0, 4);
		chk("hold", 32'h4, 32'(hold));
		wait_load;
		go(3'h0, 1'b0, 2);
		chk("busy", 32'h0, 32'(busy));
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		s_reset;
		s_hw;
		s_abort;
		s_sw;
		s_seq;
		test_done;
	end
endmodule
